// [inc/sec_pkg.sv]
// ****************************************************************
// ECC capture and inject constants
// ****************************************************************
package sec_pkg;

   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [5:0] IDX_ECC_CTRL = 6'h20;
   localparam logic [5:0] IDX_ERR_STATUS = 6'h21;
   localparam logic [5:0] IDX_ERR_BIT_POS = 6'h22;
   localparam logic [5:0] IDX_FORCE_CTRL = 6'h23;
   localparam logic [5:0] IDX_SGL_ADDR = 6'h24;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_GLOBAL_ON_BIT = 0;
   localparam int CTRL_SGL_IRQ_BIT = 1;
   localparam int CTRL_MULTI_NMI_BIT = 2;
   localparam int STAT_SGL_BIT = 0;
   localparam int STAT_MULTI_BIT = 1;
   localparam int FORCE_ARM_BIT = 7;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_MSB = 27;
   localparam int CHK_SIDE_BIT = 5;
   localparam int DATA_W = 32;
   localparam int CHK_W = 7;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] FORCE_RST = 8'h00;
   localparam logic [5:0] POS_RST = 6'h00;
   localparam logic [25:0] SGL_ADDR_RST = 26'h000_0000;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // Position offset of the check field inside the 39-bit word
   localparam logic [5:0] CHK_POS_BASE = 6'h20;

   // ****************************************************************
   // Check matrix columns, one per data bit (bit 0 rightmost)
   // ****************************************************************
   localparam logic [31:0][6:0] H_COLS = {
      7'h4C, 7'h4A, 7'h49, 7'h46, 7'h45, 7'h43, 7'h38, 7'h64,
      7'h32, 7'h31, 7'h2C, 7'h3D, 7'h2A, 7'h29, 7'h5E, 7'h26,
      7'h51, 7'h67, 7'h23, 7'h1C, 7'h1A, 7'h19, 7'h16, 7'h15,
      7'h13, 7'h0E, 7'h0D, 7'h6D, 7'h0B, 7'h07, 7'h75, 7'h37
   };

endpackage : sec_pkg

// [hdl/sec_ecc_gen.sv]
`timescale 1ns/1ps
// ****************************************************************
// Check code generator
// ****************************************************************
module sec_ecc_gen (
   // Data in
   input wire logic [31:0] i_data,
   // Code out
   output logic [6:0] o_check
);

   // Parity of data bits selected by each matrix row
   always_comb begin
      o_check = 7'h00;
      for (int i = 0; i < sec_pkg::DATA_W; i++) begin
         if (i_data[i]) begin
            o_check = o_check ^ sec_pkg::H_COLS[i];
         end
      end
   end

endmodule : sec_ecc_gen

// [hdl/sec_ecc_dec.sv]
`timescale 1ns/1ps
// ****************************************************************
// Syndrome decoder and single-bit corrector
// ****************************************************************
module sec_ecc_dec (
   // Read word
   input wire logic [31:0] i_data,
   input wire logic [6:0] i_stored,
   input wire logic [6:0] i_fresh,
   // Result
   output logic [31:0] o_data,
   output logic o_single,
   output logic o_multi,
   output logic [5:0] o_pos
);

   logic [6:0] syn;

   // Column match against the syndrome
   function automatic logic col_hit(input logic [6:0] s, input logic [6:0] col);
      col_hit = (s == col);
   endfunction : col_hit

   // Classify mismatch, flip the failing data bit
   always_comb begin
      syn = i_stored ^ i_fresh;
      o_data = i_data;
      o_single = 1'b0;
      o_multi = (syn != 7'h00);
      o_pos = sec_pkg::POS_RST;
      for (int i = 0; i < sec_pkg::DATA_W; i++) begin
         if (col_hit(syn, sec_pkg::H_COLS[i])) begin
            o_single = 1'b1;
            o_multi = 1'b0;
            o_pos = 6'(i);
            o_data[i] = ~i_data[i];
         end
      end
      for (int j = 0; j < sec_pkg::CHK_W; j++) begin
         if (col_hit(syn, 7'(1 << j))) begin
            o_single = 1'b1;
            o_multi = 1'b0;
            o_pos = sec_pkg::CHK_POS_BASE + 6'(j);
         end
      end
   end

endmodule : sec_ecc_dec

// [hdl/sec_ecc_top.sv]
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module sec_ecc_top (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_prg_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Master write request
   input wire logic i_wr_valid,
   input wire logic [31:0] i_wr_addr,
   input wire logic [31:0] i_wr_data,
   // SDRAM write side
   output logic o_mem_wr,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   output logic [6:0] o_mem_wcheck,
   output logic o_mem_wcheck_en,
   // SDRAM read return
   input wire logic i_rd_valid,
   input wire logic [31:0] i_rd_addr,
   input wire logic [31:0] i_rd_data,
   input wire logic [6:0] i_rd_check,
   // Data back to master
   output logic o_rd_valid,
   output logic [31:0] o_rd_data,
   output logic o_rd_single,
   output logic o_rd_multi,
   // Interrupt sources
   output logic o_single_irq,
   output logic o_multi_nmi
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [2:0] ctrl_q;
   logic sgl_flag_q, multi_flag_q, force_arm_q;
   logic [5:0] err_pos_q;
   logic [6:0] force_pat_q;
   logic [25:0] sgl_addr_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic mem_wr_q, mem_wcheck_en_q;
   logic [31:0] mem_addr_q, mem_wdata_q;
   logic [6:0] mem_wcheck_q;
   logic rd_valid_q, rd_single_q, rd_multi_q;
   logic [31:0] rd_data_q;
   logic single_irq_q, multi_nmi_q;
   logic [6:0] wr_code, rd_code;
   logic [31:0] fix_data, rd_mux;
   logic det_single, det_multi;
   logic [5:0] det_pos, reg_idx;
   logic reg_hit, apb_acc, apb_wr, ecc_on;
   logic sgl_set, multi_set, sgl_clr, multi_clr, sgl_capture, arm_set, arm_used;

   // Register index decode
   function automatic logic idx_is(input logic [5:0] idx, input logic [5:0] want);
      idx_is = (idx == want);
   endfunction : idx_is

   // ****************************************************************
   // Code generation and checking
   // ****************************************************************

   // Write side generator
   sec_ecc_gen u_gen_wr (
      .i_data(i_wr_data),
      .o_check(wr_code)
   );

   // Read side regenerator
   sec_ecc_gen u_gen_rd (
      .i_data(i_rd_data),
      .o_check(rd_code)
   );

   // Compare stored against regenerated code
   sec_ecc_dec u_dec (
      .i_data(i_rd_data),
      .i_stored(i_rd_check),
      .i_fresh(rd_code),
      .o_data(fix_data),
      .o_single(det_single),
      .o_multi(det_multi),
      .o_pos(det_pos)
   );

   // ****************************************************************
   // Bus decode and event terms
   // ****************************************************************

   // APB strobes and event qualifiers
   assign reg_idx = i_paddr[7:2];
   assign reg_hit = (i_paddr[1:0] == 2'b00) && (idx_is(reg_idx, sec_pkg::IDX_ECC_CTRL) ||
      idx_is(reg_idx, sec_pkg::IDX_ERR_STATUS) || idx_is(reg_idx, sec_pkg::IDX_ERR_BIT_POS) ||
      idx_is(reg_idx, sec_pkg::IDX_FORCE_CTRL) || idx_is(reg_idx, sec_pkg::IDX_SGL_ADDR));
   assign apb_acc = i_psel && i_penable && pready_q;
   assign apb_wr = apb_acc && i_pwrite && reg_hit;
   assign ecc_on = ctrl_q[sec_pkg::CTRL_GLOBAL_ON_BIT];
   assign sgl_set = i_rd_valid && ecc_on && det_single;
   assign multi_set = i_rd_valid && ecc_on && det_multi;
   assign sgl_clr = apb_wr && idx_is(reg_idx, sec_pkg::IDX_ERR_STATUS) &&
      i_pwdata[sec_pkg::STAT_SGL_BIT];
   assign multi_clr = apb_wr && idx_is(reg_idx, sec_pkg::IDX_ERR_STATUS) &&
      i_pwdata[sec_pkg::STAT_MULTI_BIT];
   assign sgl_capture = sgl_set && (!sgl_flag_q || sgl_clr);
   assign arm_set = apb_wr && idx_is(reg_idx, sec_pkg::IDX_FORCE_CTRL);
   assign arm_used = i_wr_valid && force_arm_q;

   // Read mux, reserved bits read as zero
   always_comb begin
      rd_mux = sec_pkg::RDATA_ZERO;
      case (reg_idx)
         sec_pkg::IDX_ECC_CTRL: rd_mux[2:0] = ctrl_q;
         sec_pkg::IDX_ERR_STATUS: rd_mux[1:0] = {multi_flag_q, sgl_flag_q};
         sec_pkg::IDX_ERR_BIT_POS: rd_mux[5:0] = err_pos_q;
         sec_pkg::IDX_FORCE_CTRL: rd_mux[7:0] = {force_arm_q, force_pat_q};
         sec_pkg::IDX_SGL_ADDR: rd_mux[27:2] = sgl_addr_q;
         default: rd_mux = sec_pkg::RDATA_ZERO;
      endcase
      if (i_paddr[1:0] != 2'b00) begin
         rd_mux = sec_pkg::RDATA_ZERO;
      end
   end

   // ****************************************************************
   // APB slave handshake
   // ****************************************************************

   // One wait state, then answer with data and error
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= sec_pkg::RDATA_ZERO;
      end else begin
         pready_q <= i_psel && i_penable && !pready_q;
         pslverr_q <= i_psel && i_penable && !pready_q && !reg_hit;
         if (i_psel && i_penable && !pready_q && !i_pwrite) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // Control and status registers
   // ****************************************************************

   // Control survives the programmable reset
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q <= sec_pkg::CTRL_RST;
      end else if (apb_wr && idx_is(reg_idx, sec_pkg::IDX_ECC_CTRL)) begin
         ctrl_q <= i_pwdata[2:0];
      end
   end

   // Sticky error flags, set wins over write-one-clear
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sgl_flag_q <= 1'b0;
         multi_flag_q <= 1'b0;
      end else if (i_prg_rst) begin
         sgl_flag_q <= 1'b0;
         multi_flag_q <= 1'b0;
      end else begin
         if (sgl_set) begin
            sgl_flag_q <= 1'b1;
         end else if (sgl_clr) begin
            sgl_flag_q <= 1'b0;
         end
         if (multi_set) begin
            multi_flag_q <= 1'b1;
         end else if (multi_clr) begin
            multi_flag_q <= 1'b0;
         end
      end
   end

   // First single error position and address capture
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         err_pos_q <= sec_pkg::POS_RST;
         sgl_addr_q <= sec_pkg::SGL_ADDR_RST;
      end else if (i_prg_rst) begin
         err_pos_q <= sec_pkg::POS_RST;
         sgl_addr_q <= sec_pkg::SGL_ADDR_RST;
      end else if (sgl_capture) begin
         err_pos_q <= det_pos;
         sgl_addr_q <= i_rd_addr[sec_pkg::ADDR_MSB:sec_pkg::ADDR_LSB];
      end
   end

   // Forced check code, arm consumed by the next write
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         force_arm_q <= sec_pkg::FORCE_RST[sec_pkg::FORCE_ARM_BIT];
         force_pat_q <= sec_pkg::FORCE_RST[6:0];
      end else if (i_prg_rst) begin
         force_arm_q <= sec_pkg::FORCE_RST[sec_pkg::FORCE_ARM_BIT];
         force_pat_q <= sec_pkg::FORCE_RST[6:0];
      end else if (arm_set) begin
         force_arm_q <= i_pwdata[sec_pkg::FORCE_ARM_BIT];
         force_pat_q <= i_pwdata[6:0];
      end else if (arm_used) begin
         force_arm_q <= 1'b0;
      end
   end

   // ****************************************************************
   // SDRAM write path
   // ****************************************************************

   // Register write with generated or forced code
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mem_wr_q <= 1'b0;
         mem_addr_q <= sec_pkg::RDATA_ZERO;
         mem_wdata_q <= sec_pkg::RDATA_ZERO;
         mem_wcheck_q <= 7'h00;
         mem_wcheck_en_q <= 1'b0;
      end else begin
         mem_wr_q <= i_wr_valid;
         if (i_wr_valid) begin
            mem_addr_q <= i_wr_addr;
            mem_wdata_q <= i_wr_data;
            mem_wcheck_en_q <= ecc_on;
            if (force_arm_q) begin
               mem_wcheck_q <= force_pat_q;
            end else begin
               mem_wcheck_q <= wr_code;
            end
         end
      end
   end

   // ****************************************************************
   // SDRAM read return path
   // ****************************************************************

   // Corrected or raw data back to the master
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= sec_pkg::RDATA_ZERO;
         rd_single_q <= 1'b0;
         rd_multi_q <= 1'b0;
      end else begin
         rd_valid_q <= i_rd_valid;
         rd_single_q <= sgl_set;
         rd_multi_q <= multi_set;
         if (i_rd_valid) begin
            rd_data_q <= sgl_set ? fix_data : i_rd_data;
         end
      end
   end

   // Interrupt sources follow flags gated by enables
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         single_irq_q <= 1'b0;
         multi_nmi_q <= 1'b0;
      end else begin
         single_irq_q <= sgl_flag_q && ctrl_q[sec_pkg::CTRL_SGL_IRQ_BIT];
         multi_nmi_q <= multi_flag_q && ctrl_q[sec_pkg::CTRL_MULTI_NMI_BIT];
      end
   end

   // Outputs straight from flip-flops
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_mem_wr = mem_wr_q;
   assign o_mem_addr = mem_addr_q;
   assign o_mem_wdata = mem_wdata_q;
   assign o_mem_wcheck = mem_wcheck_q;
   assign o_mem_wcheck_en = mem_wcheck_en_q;
   assign o_rd_valid = rd_valid_q;
   assign o_rd_data = rd_data_q;
   assign o_rd_single = rd_single_q;
   assign o_rd_multi = rd_multi_q;
   assign o_single_irq = single_irq_q;
   assign o_multi_nmi = multi_nmi_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   a_pos_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sgl_flag_q && !sgl_clr && !i_prg_rst |=> $stable(err_pos_q))
      else $error("error position changed while flag set");

   a_pos_in_word: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sgl_capture && !i_prg_rst |=> (err_pos_q <= 6'd38) && sgl_flag_q)
      else $error("error position outside the 39-bit word");

   a_pos_side_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sgl_capture && !i_prg_rst |=>
      err_pos_q[sec_pkg::CHK_SIDE_BIT] == ($past(i_rd_check) != $past(rd_code) &&
      $past(fix_data) == $past(i_rd_data)))
      else $error("position side bit does not match failing field");

   a_force_used: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_wr_valid && force_arm_q |=> o_mem_wr && (o_mem_wcheck == $past(force_pat_q)))
      else $error("forced pattern not written");

   a_arm_drops: assert property (@(posedge i_core_clk) disable iff (i_rst)
      arm_used && !arm_set |=> !force_arm_q ##1 (!force_arm_q || $past(arm_set)))
      else $error("arm bit not cleared after use");

   a_normal_code: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_wr_valid && !force_arm_q |=> o_mem_wcheck == $past(wr_code))
      else $error("generated code not written");

   a_code_example: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_wr_valid && !force_arm_q && i_wr_data == 32'hA5A5_A5A5 |=> o_mem_wcheck == 7'h63)
      else $error("reference code mismatch");

   a_addr_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sgl_flag_q && !sgl_clr && !i_prg_rst |=> $stable(sgl_addr_q))
      else $error("address recaptured while flag set");

   a_prg_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_prg_rst |=> err_pos_q == 6'h00 && sgl_addr_q == 26'h000_0000 && !force_arm_q &&
      force_pat_q == 7'h00)
      else $error("programmable reset left state behind");

   a_nmi_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
      multi_set && ctrl_q[sec_pkg::CTRL_MULTI_NMI_BIT] && !i_prg_rst &&
      $stable(ctrl_q) ##1 $stable(ctrl_q) |-> ##1 o_multi_nmi)
      else $error("NMI not raised for multi-bit error");

   a_no_check_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_rd_valid && !ecc_on |=> !o_rd_single && !o_rd_multi && o_rd_data == $past(i_rd_data))
      else $error("checking active with ECC off");

endmodule : sec_ecc_top

// [bench/sec_sdram_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// ECC SDRAM storage: data plus check code, read back on request
// ****************************************************************
module sec_sdram_model (
   // Clock
   input wire logic i_clk,
   // Write from the ECC block
   input wire logic i_wr,
   input wire logic [31:0] i_waddr,
   input wire logic [31:0] i_wdata,
   input wire logic [6:0] i_wcheck,
   // Read request and bit flip mask
   input wire logic i_req,
   input wire logic [31:0] i_raddr,
   input wire logic [38:0] i_flip,
   // Read return
   output logic o_valid,
   output logic [31:0] o_addr,
   output logic [31:0] o_data,
   output logic [6:0] o_check
);
   logic [38:0] mem_q [256];

   // Idle bus starts at a known level
   initial begin
      o_valid = 1'b0;
      o_addr = 32'h0000_0000;
      o_data = 32'h0000_0000;
      o_check = 7'h00;
   end

   // Store word and code; return with injected flips
   always @(posedge i_clk) begin
      if (i_wr) begin
         mem_q[i_waddr[9:2]] <= {i_wcheck, i_wdata};
      end
      o_valid <= i_req;
      if (i_req) begin
         {o_check, o_data} <= mem_q[i_raddr[9:2]] ^ i_flip;
         o_addr <= i_raddr;
      end else begin
         o_data <= ~o_data; // Released bus keeps moving
         o_check <= ~o_check;
      end
   end
endmodule : sec_sdram_model

// [bench/tb_sec_ecc_top.sv]
`timescale 1ns/1ps
module tb_sec_ecc_top;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_prg_rst = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic i_wr_valid = 1'b0;
   logic [31:0] i_wr_addr = 32'h0000_0000, i_wr_data = 32'h0000_0000;
   logic i_rd_valid, o_pready, o_pslverr, o_mem_wr, o_mem_wcheck_en, re;
   logic [31:0] i_rd_addr, i_rd_data, o_prdata, o_mem_addr, o_mem_wdata, o_rd_data, rv;
   logic [6:0] i_rd_check, o_mem_wcheck;
   logic o_rd_valid, o_rd_single, o_rd_multi, o_single_irq, o_multi_nmi;
   logic req = 1'b0;
   logic [31:0] req_addr = 32'h0000_0000;
   logic [38:0] flip = 39'h00_0000_0000;
   logic [31:0] dt [7] = '{32'h0, 32'hFFFF_FFFF, 32'hBC, 32'hA5A5_A5A5, 32'hC0C0_C0C0,
      32'h00AB_0000, 32'h00BC_0000};
   logic [6:0] ct [7] = '{7'h00, 7'h00, 7'h7F, 7'h63, 7'h2E, 7'h4C, 7'h20};
   int error_cnt = 0, compares = 0;

   always #2 i_core_clk = ~i_core_clk;

   sec_ecc_top dut (.i_core_clk, .i_rst, .i_prg_rst, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_wr_valid, .i_wr_addr,
      .i_wr_data, .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_mem_wcheck, .o_mem_wcheck_en,
      .i_rd_valid, .i_rd_addr, .i_rd_data, .i_rd_check, .o_rd_valid, .o_rd_data,
      .o_rd_single, .o_rd_multi, .o_single_irq, .o_multi_nmi);

   sec_sdram_model mem (.i_clk(i_core_clk), .i_wr(o_mem_wr), .i_waddr(o_mem_addr),
      .i_wdata(o_mem_wdata), .i_wcheck(o_mem_wcheck), .i_req(req), .i_raddr(req_addr),
      .i_flip(flip), .o_valid(i_rd_valid), .o_addr(i_rd_addr), .o_data(i_rd_data),
      .o_check(i_rd_check));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task end_of_test;
      $display("compares=%0d mismatches=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // APB transfer; pready, prdata sampled at the same edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      @(posedge i_core_clk);
      while (o_pready !== 1'b1) begin
         n++;
         if (n > 16) begin
            error_cnt++;
            end_of_test;
         end
         @(posedge i_core_clk);
      end
      rv = o_prdata;
      re = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task rreg(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask : rreg

   // Master write; next cycle shows the SDRAM write and its code
   task mwr(input logic [31:0] a, input logic [31:0] d, input logic [6:0] c);
      @(posedge i_core_clk);
      i_wr_valid <= 1'b1;
      i_wr_addr <= a;
      i_wr_data <= d;
      @(posedge i_core_clk);
      i_wr_valid <= 1'b0;
      #1;
      chk({o_mem_wr, o_mem_wcheck_en, o_mem_wcheck}, {2'b11, c});
   endtask : mwr

   // Storage read with flips; waits for the returned word
   task mrd(input logic [31:0] a, input logic [38:0] f);
      int n;
      @(posedge i_core_clk);
      req <= 1'b1;
      req_addr <= a;
      flip <= f;
      @(posedge i_core_clk);
      req <= 1'b0;
      for (n = 0; n < 8 && o_rd_valid !== 1'b1; n++) begin
         @(posedge i_core_clk);
         #1;
      end
      if (n == 8) begin
         error_cnt++;
         end_of_test;
      end
   endtask : mrd

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rreg(8'h8C, 32'h0);
      rreg(8'h90, 32'h0);
      rreg(8'h88, 32'h0);
      apb(1'b0, 8'h44, 32'h0);
      chk({31'h0, re}, 32'h1);
      $display("test reset done");
      apb(1'b1, 8'h80, 32'h7);
      for (int i = 0; i < 7; i++) begin
         mwr(i * 4, dt[i], ct[i]);
         mrd(i * 4, 39'h0);
         chk({o_rd_single, o_rd_multi, o_rd_data}, {2'b00, dt[i]});
      end
      $display("test codes done");
      mwr(32'hF123_456B, 32'hA5A5_A5A5, 7'h63);
      mrd(32'hF123_456B, 39'h200);
      chk({o_rd_single, o_rd_multi, o_rd_data}, {2'b10, 32'hA5A5_A5A5});
      rreg(8'h88, 32'h9);
      rreg(8'h90, 32'h0123_4568);
      rreg(8'h84, 32'h1);
      chk(o_single_irq, 1'b1);
      mwr(32'h40, 32'hC0C0_C0C0, 7'h2E);
      mrd(32'h40, 39'h08_0000_0000);
      chk(o_rd_data, 32'hC0C0_C0C0);
      rreg(8'h88, 32'h9);
      rreg(8'h90, 32'h0123_4568);
      apb(1'b1, 8'h84, 32'h1);
      rreg(8'h84, 32'h0);
      mrd(32'h40, 39'h08_0000_0000);
      rreg(8'h88, 32'h23);
      rreg(8'h90, 32'h40);
      $display("test single done");
      mrd(32'h40, 39'h3);
      chk({o_rd_single, o_rd_multi, o_rd_data}, {2'b01, 32'hC0C0_C0C3});
      rreg(8'h84, 32'h3);
      chk(o_multi_nmi, 1'b1);
      apb(1'b1, 8'h84, 32'h3);
      $display("test multi done");
      apb(1'b1, 8'h8C, 32'h81);
      rreg(8'h8C, 32'h81);
      mwr(32'h44, 32'h0, 7'h01);
      rreg(8'h8C, 32'h01);
      mwr(32'h48, 32'h0, 7'h00);
      mrd(32'h44, 39'h0);
      chk({o_rd_single, o_rd_multi}, 2'b10);
      rreg(8'h88, 32'h20);
      apb(1'b1, 8'h8C, 32'h7F);
      mwr(32'h4C, 32'h00BC_0000, 7'h20);
      $display("test force done");
      apb(1'b1, 8'h84, 32'h3);
      apb(1'b1, 8'h80, 32'h0);
      mrd(32'h40, 39'h200);
      chk({o_rd_single, o_rd_multi}, 2'b00);
      rreg(8'h84, 32'h0);
      $display("test off done");
      apb(1'b1, 8'h80, 32'h7);
      mrd(32'h44, 39'h0);
      apb(1'b1, 8'h8C, 32'h85);
      @(posedge i_core_clk);
      i_prg_rst <= 1'b1;
      @(posedge i_core_clk);
      i_prg_rst <= 1'b0;
      rreg(8'h88, 32'h0);
      rreg(8'h90, 32'h0);
      rreg(8'h8C, 32'h0);
      rreg(8'h80, 32'h7);
      $display("test prg reset done");
      end_of_test;
   end
endmodule : tb_sec_ecc_top
